// file: rtl/nvec_ctrl.sv
`timescale 1ns/1ps
`include "nvec_map.svh"
// What this block does
// - Page erase happens only in page mode and clears the tagged bytes of one 16-byte page.
// - Page buffer clears at reset and on erase enable falling, not rising.
// - Page mode: upper 6 address bits fixed, lower 4 saturate at 0fh.
// - Each data write during page erase tags the current address.
// - Erase starts only on erase trigger right after erase or write enable set.
// - Slow timer times erase; erase trigger clears at cycle end.
// - Erase enable clears in hardware after erase finishes.
// - Erased page locations read back as zero.
// - Byte mode write starts on trigger right after write enable set.
// - Write trigger ignored unless write enable already high.
// - Slow timer times write; write trigger clears when data written.
// - Byte write erases the target byte first.
// - Page buffer clears on write enable falling, not on rising.
// - Page mode data writes load buffer and bump lower address.
// - Data writes after location 0fh has been loaded are dropped.
// - Write enable clears in hardware after write finishes.
// - Reset clears write enable and memory pointer high bytes.
// - Cycle end sets both flags; vector needs all enables, stack not full.
// - Servicing clears only multi-function flag and global enable.
// - Timing select picks 3.2/2.2 ms or 3.7/3.0 ms.
// - Address is 10 bits: 8 low plus 2 high.
module nvec_ctrl
  import nvec_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Interrupt controller side
  input wire logic STACK_FULL_I,
  input wire logic IRQ_ACK_I,
  output logic IRQ_VECTOR_O,
  // Busy status
  output logic BUSY_O
);
  import nvec_pkg::*;

  nvec_byte_t addr_low;
  logic [1:0] addr_high;
  nvec_byte_t data_reg;
  logic tsel, erase_en, erase_trg, mode, wr_en, wr_trg;
  logic gie, die, mie, dif, mif;
  nvec_byte_t mptr1_high, mptr2_high;
  nvec_byte_t page_buf [16];
  logic [15:0] tag;
  nvec_byte_t array_mem [1024];
  nvec_addr_t rd_addr;
  nvec_state_e state;
  logic [15:0] div_cnt;
  logic slow_tick;
  logic [7:0] tick_cnt;
  logic en_prev_cycle;
  logic erase_prev, wr_prev;
  logic done;

  wire logic acc = PSEL_I && PENABLE_I;
  wire logic wr_acc = acc && PWRITE_I;
  wire nvec_addr_t cur_addr = {addr_high, addr_low};
  wire logic [3:0] lo4 = addr_low[3:0];
  wire logic data_wr = wr_acc && PADDR_I == `NVEC_OFF_DATA;
  wire logic ctl_wr = wr_acc && PADDR_I == `NVEC_OFF_CONTROL;
  wire logic idle = state == NVEC_IDLE;
  // Host may not touch registers mid-cycle, so bytes are only taken idle
  wire logic page_load = data_wr && mode && idle && !(lo4 == `NVEC_PAGE_LAST
    && tag[`NVEC_PAGE_LAST]);
  wire logic start_erase = ctl_wr && idle && PWDATA_I[`NVEC_BIT_ERTRG]
    && erase_en && en_prev_cycle && mode;
  wire logic start_write = ctl_wr && idle && PWDATA_I[`NVEC_BIT_WRTRG]
    && wr_en && en_prev_cycle;

  assign PREADY_O = 1'b1;
  assign BUSY_O = !idle;

  always_comb
  begin
    PSLVERR_O = 1'b0;
    if (acc && PADDR_I > `NVEC_OFF_ARRAY_DATA)
    begin
      PSLVERR_O = 1'b1;
    end
  end

  // Read data from flip-flops: registered one cycle ahead in setup phase
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      PRDATA_O <= 32'h0;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I)
    begin
      case (PADDR_I)
        `NVEC_OFF_ADDR_LOW: PRDATA_O <= {24'h0, addr_low};
        `NVEC_OFF_ADDR_HIGH: PRDATA_O <= {30'h0, addr_high};
        `NVEC_OFF_DATA: PRDATA_O <= {24'h0, data_reg};
        `NVEC_OFF_CONTROL: PRDATA_O <= {24'h0, tsel, erase_en, erase_trg,
          mode, wr_en, wr_trg, 2'b00};
        `NVEC_OFF_IRQ: PRDATA_O <= {27'h0, mif, dif, mie, die, gie};
        `NVEC_OFF_MEMPTR: PRDATA_O <= {16'h0, mptr2_high, mptr1_high};
        `NVEC_OFF_ARRAY_ADDR: PRDATA_O <= {22'h0, rd_addr};
        `NVEC_OFF_ARRAY_DATA: PRDATA_O <= {24'h0, array_mem[rd_addr]};
        default: PRDATA_O <= 32'h0;
      endcase
    end
  end

  // Arm window: enable written in the previous access cycle
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      en_prev_cycle <= 1'b0;
    else if (acc)
      en_prev_cycle <= ctl_wr && (PWDATA_I[`NVEC_BIT_ERASE_EN] && !erase_en
        || PWDATA_I[`NVEC_BIT_WR_EN] && !wr_en);
  end

  // Slow timer tick standing in for the asynchronous cycle timer
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      div_cnt <= 16'h0;
    else if (div_cnt == 16'(`NVEC_SLOW_DIV - 1))
      div_cnt <= 16'h0;
    else
      div_cnt <= div_cnt + 16'h1;
  end
  assign slow_tick = div_cnt == 16'(`NVEC_SLOW_DIV - 1);

  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state <= NVEC_IDLE;
      tick_cnt <= 8'h0;
    end
    else
    begin
      case (state)
        NVEC_IDLE:
        begin
          if (start_erase)
          begin
            state <= NVEC_ERASE;
            tick_cnt <= tsel ? 8'(`NVEC_TICKS(`NVEC_ERASE_US_1))
              : 8'(`NVEC_TICKS(`NVEC_ERASE_US_0));
          end
          else if (start_write)
          begin
            state <= NVEC_WRITE;
            tick_cnt <= tsel ? 8'(`NVEC_TICKS(`NVEC_WRITE_US_1))
              : 8'(`NVEC_TICKS(`NVEC_WRITE_US_0));
          end
        end
        NVEC_ERASE, NVEC_WRITE:
        begin
          if (done)
            state <= NVEC_IDLE;
          else if (slow_tick)
            tick_cnt <= tick_cnt - 8'h1;
        end
        default: state <= NVEC_IDLE;
      endcase
    end
  end
  assign done = !idle && slow_tick && tick_cnt == 8'h1;

  // Control register with hardware clears at cycle end
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      {tsel, erase_en, erase_trg, mode, wr_en, wr_trg} <= 6'h0;
    end
    else if (done)
    begin
      if (state == NVEC_ERASE)
      begin
        erase_trg <= 1'b0;
        erase_en <= 1'b0;
      end
      else
      begin
        wr_trg <= 1'b0;
        wr_en <= 1'b0;
      end
    end
    else if (ctl_wr && idle)
    begin
      tsel <= PWDATA_I[`NVEC_BIT_TSEL];
      mode <= PWDATA_I[`NVEC_BIT_MODE];
      erase_en <= PWDATA_I[`NVEC_BIT_ERASE_EN];
      wr_en <= PWDATA_I[`NVEC_BIT_WR_EN];
      erase_trg <= start_erase;
      wr_trg <= start_write;
    end
  end

  // Address and data registers
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      addr_low <= `NVEC_ZERO8;
      addr_high <= 2'b00;
      data_reg <= `NVEC_ZERO8;
      rd_addr <= 10'h0;
    end
    else if (wr_acc && idle)
    begin
      if (PADDR_I == `NVEC_OFF_ADDR_LOW)
        addr_low <= PWDATA_I[7:0];
      if (PADDR_I == `NVEC_OFF_ADDR_HIGH)
        addr_high <= PWDATA_I[1:0];
      if (PADDR_I == `NVEC_OFF_ARRAY_ADDR)
        rd_addr <= PWDATA_I[9:0];
      if (data_wr)
        data_reg <= PWDATA_I[7:0];
      if (page_load && lo4 != `NVEC_PAGE_LAST)
        addr_low[3:0] <= lo4 + 4'h1;
    end
  end

  // Page buffer and erase tags, cleared on falling enables
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      erase_prev <= 1'b0;
      wr_prev <= 1'b0;
    end
    else
    begin
      erase_prev <= erase_en;
      wr_prev <= wr_en;
    end
  end
  wire logic buf_clear = (erase_prev && !erase_en) || (wr_prev && !wr_en);

  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      tag <= 16'h0;
    else if (buf_clear)
      tag <= 16'h0;
    else if (page_load)
      tag[lo4] <= 1'b1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_buf
      always_ff @(posedge CLOCK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
          page_buf[gi] <= `NVEC_ZERO8;
        else if (buf_clear)
          page_buf[gi] <= `NVEC_ZERO8;
        else if (page_load && lo4 == 4'(gi))
          page_buf[gi] <= PWDATA_I[7:0];
      end
    end
  endgenerate

  // Array update at cycle end; the byte write overwrites, which erases first
  always_ff @(posedge CLOCK_I)
  begin
    if (done && state == NVEC_ERASE)
    begin
      for (int i = 0; i < 16; i++)
        if (tag[i])
          array_mem[{addr_high, addr_low[7:4], 4'(i)}] <= `NVEC_ZERO8;
    end
    else if (done && !mode)
      array_mem[cur_addr] <= data_reg;
    else if (done)
    begin
      for (int i = 0; i < 16; i++)
        if (tag[i])
          array_mem[{addr_high, addr_low[7:4], 4'(i)}] <= page_buf[i];
    end
  end

  // Interrupt flags: set wins over clear
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      {gie, die, mie, dif, mif} <= 5'h0;
    else
    begin
      if (wr_acc && PADDR_I == `NVEC_OFF_IRQ)
      begin
        gie <= PWDATA_I[`NVEC_BIT_GIE];
        die <= PWDATA_I[`NVEC_BIT_DIE];
        mie <= PWDATA_I[`NVEC_BIT_MIE];
        dif <= PWDATA_I[`NVEC_BIT_DIF] || done;
        mif <= PWDATA_I[`NVEC_BIT_MIF] || done;
      end
      else
      begin
        // A service drops the global enable even when a cycle ends with it
        if (IRQ_ACK_I)
          gie <= 1'b0;
        if (done)
        begin
          dif <= 1'b1;
          mif <= 1'b1;
        end
        else if (IRQ_ACK_I)
          mif <= 1'b0;
      end
    end
  end
  assign IRQ_VECTOR_O = gie && die && mie && mif && !STACK_FULL_I;

  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      mptr1_high <= `NVEC_ZERO8;
      mptr2_high <= `NVEC_ZERO8;
    end
    else if (wr_acc && PADDR_I == `NVEC_OFF_MEMPTR)
    begin
      mptr1_high <= PWDATA_I[7:0];
      mptr2_high <= PWDATA_I[15:8];
    end
  end

  a_trig_needs_arm: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    $rose(wr_trg) |-> $past(wr_en) && $past(en_prev_cycle))
    else $error("write trigger set without armed enable");
  // Mode may be rewritten by the trigger access itself, so look one back
  a_erase_page_mode: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    $rose(erase_trg) |-> $past(mode))
    else $error("erase started outside page mode");
  a_erase_end_clear: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    done && state == NVEC_ERASE |=> !erase_trg && !erase_en)
    else $error("erase bits not cleared at end");
  a_write_end_clear: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    done && state == NVEC_WRITE |=> !wr_trg && !wr_en && dif)
    else $error("write bits not cleared at end");
  a_addr_saturate: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    page_load |=> addr_low[7:4] == $past(addr_low[7:4])
    && addr_low[3:0] != 4'h0)
    else $error("page address rolled or page bits moved");
  a_buf_clear_fall: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    $fell(wr_en) |=> ##1 tag == 16'h0)
    else $error("page buffer not cleared on enable fall");
  a_erase_fall_clear: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    $fell(erase_en) |=> tag == 16'h0)
    else $error("tags not cleared on erase enable fall");
  a_flag_on_done: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    done |=> dif && mif)
    else $error("flags not set at cycle end");
  a_trig_held_busy: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    state == NVEC_WRITE && !done |=> wr_trg)
    else $error("write trigger dropped early");
  a_erase_trig_held: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    state == NVEC_ERASE && !done |=> erase_trg)
    else $error("erase trigger dropped early");
  a_byte_mode_addr: assert property (
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    data_wr && !mode |=> addr_low == $past(addr_low))
    else $error("byte mode changed address");
endmodule // nvec_ctrl

// file: pkg/nvec_map.svh
`ifndef NVEC_MAP_SVH
`define NVEC_MAP_SVH
// Register byte offsets on APB
`define NVEC_OFF_ADDR_LOW 12'h000
`define NVEC_OFF_ADDR_HIGH 12'h004
`define NVEC_OFF_DATA 12'h008
`define NVEC_OFF_CONTROL 12'h00c
`define NVEC_OFF_IRQ 12'h010
`define NVEC_OFF_MEMPTR 12'h014
`define NVEC_OFF_ARRAY_ADDR 12'h018
`define NVEC_OFF_ARRAY_DATA 12'h01c
// Control register bit positions
`define NVEC_BIT_TSEL 7
`define NVEC_BIT_ERASE_EN 6
`define NVEC_BIT_ERTRG 5
`define NVEC_BIT_MODE 4
`define NVEC_BIT_WR_EN 3
`define NVEC_BIT_WRTRG 2
// Interrupt register bit positions
`define NVEC_BIT_GIE 0
`define NVEC_BIT_DIE 1
`define NVEC_BIT_MIE 2
`define NVEC_BIT_DIF 3
`define NVEC_BIT_MIF 4
// Cycle times in microseconds, slow timer rate in Hz
`define NVEC_ERASE_US_0 3200
`define NVEC_WRITE_US_0 2200
`define NVEC_ERASE_US_1 3700
`define NVEC_WRITE_US_1 3000
`define NVEC_CLK_HZ 50000000
`define NVEC_SLOW_HZ 32000
`define NVEC_SLOW_DIV (`NVEC_CLK_HZ / `NVEC_SLOW_HZ)
// Slow ticks per cycle, rounded down
`define NVEC_TICKS(us) ((us) * `NVEC_SLOW_HZ / 1000000)
`define NVEC_PAGE_LAST 4'hf
`define NVEC_ZERO8 8'h00
`endif

// file: pkg/nvec_pkg.sv
package nvec_pkg;
  typedef enum logic [1:0] {NVEC_IDLE, NVEC_ERASE, NVEC_WRITE} nvec_state_e;
  typedef logic [9:0] nvec_addr_t;
  typedef logic [7:0] nvec_byte_t;
endpackage

// file: tb/nvec_core_model.sv
`timescale 1ns/1ps
module nvec_core_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench control
  input wire logic stall_i,
  // Device side
  input wire logic vector_i,
  output logic stack_full_o,
  output logic ack_o
);
  // Stall stands for a full stack, so no vector can be taken meanwhile
  assign stack_full_o = stall_i;
  // One-cycle service pulse; the gap keeps one vector from being acked twice
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= vector_i && !ack_o && !stall_i;
    end
  end
endmodule // nvec_core_model

// file: tb/tb.sv
`timescale 1ns/1ps
`include "nvec_map.svh"
module tb;
  import nvec_pkg::*;
  localparam logic [11:0] off_low = `NVEC_OFF_ADDR_LOW;
  localparam logic [11:0] off_ctl = `NVEC_OFF_CONTROL;
  localparam logic [11:0] off_dat = `NVEC_OFF_DATA;
  localparam logic [11:0] off_irq = `NVEC_OFF_IRQ;
  logic clk, rst_n, psel, penable, pwrite, stall;
  logic pready, pslverr, irq_vec, busy, full, ack, lerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total, checks_done, k;
  integer seed;
  nvec_byte_t dat, lo;
  nvec_addr_t adr;

  nvec_ctrl nvec_ctrl_inst (.CLOCK_I(clk), .RESET_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .STACK_FULL_I(full),
    .IRQ_ACK_I(ack), .IRQ_VECTOR_O(irq_vec), .BUSY_O(busy));
  nvec_core_model nvec_core_model_inst (.clk_i(clk), .rst_n_i(rst_n),
    .stall_i(stall), .vector_i(irq_vec), .stack_full_o(full),
    .ack_o(ack));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize();
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Held from setup until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      summarize();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask

  task automatic busy_is(input logic e);
    @(posedge clk);
    #1;
    cmp({31'h0, busy}, {31'h0, e});
  endtask

  // Lower nibble steps once per data write and sticks at the page end
  function automatic nvec_byte_t exp_lo(input nvec_byte_t b, input int n);
    int s;
    s = b[3:0] + n;
    return {b[7:4], (s > 15) ? 4'hf : s[3:0]};
  endfunction

  initial
  begin
    seed = 32'h178023c7;
    err_total = 0;
    checks_done = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stall = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 6; k++)
      rdchk(12'(4 * k), 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    cmp({31'h0, lerr}, 32'h1);
    // Activations that must be refused
    wr(off_ctl, 32'h04);
    busy_is(1'b0);
    wr(off_ctl, 32'h40);
    wr(off_ctl, 32'h60);
    busy_is(1'b0);
    wr(off_ctl, 32'h00);
    wr(off_ctl, 32'h08);
    wr(off_dat, 32'h5a);
    wr(off_ctl, 32'h0c);
    busy_is(1'b0);
    wr(off_ctl, 32'h00);
    // Page mode address stepping, past the page end
    lo = nvec_byte_t'($random(seed));
    wr(off_low, {24'h0, lo});
    wr(off_ctl, 32'h10);
    for (k = 1; k < 18; k++)
    begin
      wr(off_dat, 32'($random(seed)) & 32'hff);
      rdchk(off_low, {24'h0, exp_lo(lo, k)});
    end
    // Tags dropped by an erase enable fall; no page write without an erase
    wr(off_ctl, 32'h50);
    wr(off_ctl, 32'h10);
    // Long page erase armed, then cut short by a reset in mid-cycle
    wr(off_irq, 32'h06);
    wr(off_ctl, 32'hd0);
    wr(off_ctl, 32'hf0);
    busy_is(1'b1);
    wr(off_irq, 32'h07);
    rdchk(off_ctl, 32'hf0);
    wr(off_low, 32'h33);
    rdchk(off_low, {24'h0, exp_lo(lo, 17)});
    dat = nvec_byte_t'($random(seed));
    wr(`NVEC_OFF_MEMPTR, {16'h0, dat, ~dat});
    rdchk(`NVEC_OFF_MEMPTR, {16'h0, dat, ~dat});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    busy_is(1'b0);
    rdchk(off_ctl, 32'h0);
    rdchk(`NVEC_OFF_MEMPTR, 32'h0);
    rdchk(off_irq, 32'h0);
    // Byte write with the interrupt held off by a full stack
    adr = nvec_addr_t'($random(seed));
    dat = nvec_byte_t'($random(seed));
    wr(off_low, {24'h0, adr[7:0]});
    wr(`NVEC_OFF_ADDR_HIGH, {30'h0, adr[9:8]});
    wr(off_dat, {24'h0, dat});
    rdchk(off_low, {24'h0, adr[7:0]});
    wr(off_irq, 32'h06);
    wr(off_ctl, 32'h08);
    wr(off_ctl, 32'h0c);
    busy_is(1'b1);
    wr(off_irq, 32'h07);
    k = 0;
    do
    begin
      apb(1'b0, off_ctl, 32'h0);
      k++;
    end
    while (rd[2] !== 1'b0 && k < 60000);
    if (k >= 60000)
    begin
      err_total++;
      summarize();
    end
    cmp(rd, 32'h0);
    cmp({31'h0, irq_vec}, 32'h0);
    rdchk(off_irq, 32'h1f);
    stall <= 1'b0;
    @(posedge clk);
    #1;
    cmp({31'h0, irq_vec}, 32'h1);
    repeat (3) @(posedge clk);
    rdchk(off_irq, 32'h0e);
    wr(`NVEC_OFF_ARRAY_ADDR, {22'h0, adr});
    rdchk(`NVEC_OFF_ARRAY_DATA, {24'h0, dat});
    summarize();
  end
endmodule // tb
